// *** rfe_pkg.sv ***
package rfe_pkg;

  // Clock and pattern time base
  localparam int CLK_PERIOD_NS  = 40;       // 25 MHz system clock
  localparam int TICK_PERIOD_NS = 1000000;  // One pattern step of 1 ms
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial slave address (7 bits)
  localparam logic [6:0] I2C_DEV_ADDR = 7'h30;

  // Register offsets
  localparam logic [7:0] OFS_RAMP_SCALE = 8'h00;  // Ramp time multiplier
  localparam logic [7:0] OFS_FLASH      = 8'h01;  // Flash period and ramp style
  localparam logic [7:0] OFS_TMR1       = 8'h02;  // First timer on-time
  localparam logic [7:0] OFS_TMR2       = 8'h03;  // Second timer on-time
  localparam logic [7:0] OFS_MODE       = 8'h04;  // Channel mode select
  localparam logic [7:0] OFS_RAMP       = 8'h05;  // Rise and fall time codes
  localparam logic [7:0] OFS_CUR0       = 8'h06;  // Channel 1 current
  localparam logic [7:0] OFS_CUR1       = 8'h07;  // Channel 2 current
  localparam logic [7:0] OFS_CUR2       = 8'h08;  // Channel 3 current

  // Field positions
  localparam int FLASH_CODE_LSB = 0;  // Seven-bit period code
  localparam int RAMP_STYLE_BIT = 7;  // 1 = logarithmic s-shape
  localparam int RISE_LSB       = 0;  // Four-bit rise code
  localparam int FALL_LSB       = 4;  // Four-bit fall code
  localparam int SCALE_LSB      = 0;  // Two-bit shift of ramp times

  // Reset values
  localparam logic [7:0] RST_SCALE = 8'h00;
  localparam logic [7:0] RST_FLASH = 8'h00;
  localparam logic [7:0] RST_TMR   = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_RAMP  = 8'h00;
  localparam logic [7:0] RST_CUR   = 8'h00;

  // Limits and pattern timing, in 1 ms steps
  localparam logic [7:0]  CUR_MAX        = 8'hbf;   // 191 steps of 0.125 mA
  localparam logic [6:0]  FLASH_ONE_SHOT = 7'h7f;   // Single flash code
  localparam logic [15:0] FLASH_BASE_MS  = 16'h0100;
  localparam logic [15:0] FLASH_STEP_MS  = 16'h0080;
  localparam logic [15:0] RAMP_STEP_MS   = 16'h0080;
  localparam logic [7:0]  LEVEL_FULL     = 8'hff;   // Steady, unpulsed drive

  // Per-channel mode codes
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_ON  = 2'b01,
    MODE_T1  = 2'b10,
    MODE_T2  = 2'b11
  } rfe_mode_t;

  // One completed register write
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rfe_wr_t;

  // Timing handed to each blink timer
  typedef struct packed {
    logic [15:0] period_ms;
    logic [7:0]  on_code;
    logic [15:0] rise_ms;
    logic [15:0] fall_ms;
    logic        log_style;
  } rfe_tmr_cfg_t;

endpackage

// *** rfe_i2c_wr.sv ***
module rfe_i2c_wr
  import rfe_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Serial pins, taken as synchronous
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // Completed register writes
  output rfe_wr_t   o_wr
);

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_AACK = 7'b0000100,
    S_REG  = 7'b0001000,
    S_RACK = 7'b0010000,
    S_DATA = 7'b0100000,
    S_DACK = 7'b1000000
  } rfe_i2c_st_t;

  typedef struct packed {
    rfe_i2c_st_t st;   // Transfer phase
    logic        scl;  // Previous clock sample
    logic        sda;  // Previous data sample
    logic [7:0]  sh;   // Incoming byte
    logic [3:0]  cnt;  // Bits taken
    logic [7:0]  ptr;  // Register pointer
    logic        oe;   // Pulling data low
    rfe_wr_t     wr;   // Write pulse
  } rfe_i2c_q_t;

  localparam rfe_i2c_q_t I2C_RST = '{st: S_IDLE, scl: 1'b1, sda: 1'b1, sh: 8'h00,
                                     cnt: 4'h0, ptr: 8'h00, oe: 1'b0, wr: '0};

  rfe_i2c_q_t s_q;  // Registered state
  rfe_i2c_q_t s_d;  // Next state
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // Bus sequencing; start and stop override any phase
  always_comb begin
    scl_rise = i_scl & ~s_q.scl;
    scl_fall = ~i_scl & s_q.scl;
    start_c  = i_scl & s_q.scl & s_q.sda & ~i_sda;
    stop_c   = i_scl & s_q.scl & ~s_q.sda & i_sda;
    s_d      = s_q;
    s_d.scl  = i_scl;
    s_d.sda  = i_sda;
    s_d.wr   = '0;
    unique case (s_q.st)
      S_IDLE: ;
      S_ADDR, S_REG, S_DATA: begin
        // Shift on rising clock, decide after eighth bit
        if (scl_rise && s_q.cnt != 4'h8) begin
          s_d.sh  = {s_q.sh[6:0], i_sda};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        if (scl_fall && s_q.cnt == 4'h8) begin
          s_d.oe  = 1'b1;
          s_d.cnt = 4'h0;
          if (s_q.st == S_ADDR) begin
            // Reads are not served, so a read address is left unanswered
            if (s_q.sh[7:1] == DEV_ADDR && !s_q.sh[0]) begin
              s_d.st = S_AACK;
            end else begin
              s_d.st = S_IDLE;
              s_d.oe = 1'b0;
            end
          end else if (s_q.st == S_REG) begin
            s_d.ptr = s_q.sh;
            s_d.st  = S_RACK;
          end else begin
            s_d.st = S_DACK;
          end
        end
      end
      S_AACK: if (scl_fall) begin
        s_d.oe = 1'b0;
        s_d.st = S_REG;
      end
      S_RACK: if (scl_fall) begin
        s_d.oe = 1'b0;
        s_d.st = S_DATA;
      end
      S_DACK: if (scl_fall) begin
        // Whole byte acknowledged, hand it on and step the pointer
        s_d.oe = 1'b0;
        s_d.wr = '{en: 1'b1, addr: s_q.ptr, data: s_q.sh};
        s_d.ptr = s_q.ptr + 8'h01;
        s_d.st = S_DATA;
      end
    endcase
    if (start_c) begin
      s_d.st  = S_ADDR;
      s_d.cnt = 4'h0;
      s_d.oe  = 1'b0;
    end else if (stop_c) begin
      s_d.st = S_IDLE;
      s_d.oe = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_q <= I2C_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sda_out = 1'b0;  // Open drain: only ever pulls low
  assign o_sda_oe  = s_q.oe;
  assign o_wr      = s_q.wr;

endmodule // rfe_i2c_wr

// *** rfe_ramp_timer.sv ***
module rfe_ramp_timer
  import rfe_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  // Timing and position in the flash period
  input  rfe_tmr_cfg_t i_cfg,
  input  wire logic [15:0] i_phase,
  input  wire logic   i_run,
  // Brightness level, full scale is steady on
  output logic [7:0]  o_level
);

  typedef struct packed {
    logic [7:0] level;
  } rfe_tmr_q_t;

  rfe_tmr_q_t  s_q;     // Registered state
  rfe_tmr_q_t  s_d;     // Next state
  logic [23:0] on_prod; // Period times on-time code
  logic [15:0] on_ms;   // On window, ramp included
  logic [15:0] off_e;   // Time since on window closed
  logic [7:0]  lin;     // Linear level

  // Fraction e/d scaled to 0..255; only called with e below d
  function automatic logic [7:0] frac(input logic [15:0] e, input logic [15:0] d);
    logic [23:0] p;
    p = ({8'h00, e} * 24'd255) / {8'h00, d};
    return p[7:0];
  endfunction

  // S-shaped curve: slow start and slow finish
  function automatic logic [7:0] s_curve(input logic [7:0] l);
    logic [15:0] sq;
    logic [7:0]  m;
    m  = l[7] ? (LEVEL_FULL - l) : l;
    sq = m * m;
    return l[7] ? (LEVEL_FULL - sq[14:7]) : sq[14:7];
  endfunction

  // Level from position in the period
  always_comb begin
    on_prod = i_cfg.period_ms * i_cfg.on_code;
    on_ms   = on_prod[23:8];
    off_e   = i_phase - on_ms;
    s_d     = s_q;
    lin     = 8'h00;
    if (!i_run) begin
      lin = 8'h00;
    end else if (i_phase < on_ms) begin
      // Rise sits inside the on window
      lin = (i_phase < i_cfg.rise_ms) ? frac(i_phase, i_cfg.rise_ms) : LEVEL_FULL;
    end else if (off_e < i_cfg.fall_ms) begin
      lin = LEVEL_FULL - frac(off_e, i_cfg.fall_ms);
    end
    s_d.level = i_cfg.log_style ? s_curve(lin) : lin;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule // rfe_ramp_timer

// *** rfe_flash_engine.sv ***
// Summary of operation
// - Period codes 0 to 0x7E repeat, longer upward
// - Top period code flashes once, then stops
// - Timer code 0..255 sets on-time fraction
// - On-time includes the rising ramp
// - Rise and fall codes span 0 to 0xF
// - Scaling multiplies both rise and fall times
// - Style bit picks linear or s-shaped ramps
// - Steady current when on, none when off
// - Ramps are PWM with rising or falling duty
// - Rise and fall durations set independently
// - Each channel has its own current register
// - 0x08 puts channel 2 on timer one
// - First timer on-time lives at offset 2
// - Rise and fall codes live at offset 5
// - Two mode bits per channel select behaviour
// - Current code 0 to 191, 0.125 mA steps
// - First timer pulse starts at period start
// - Mode register at 0x04; 0x01 lights channel 1
module rfe_flash_engine
  import rfe_pkg::*;
#(
  parameter int         TICK_CYCLES_P = TICK_CYCLES,  // Clocks per 1 ms step
  parameter logic [6:0] DEV_ADDR      = I2C_DEV_ADDR
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Serial configuration port
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  // Channel sinks
  output logic [2:0]       o_chan_drive,
  output logic [2:0][7:0]  o_chan_current,
  // Pattern status
  output logic             o_pattern_done
);

  // Engine phases
  typedef enum logic [1:0] {
    ENG_RUN  = 2'b01,
    ENG_DONE = 2'b10
  } rfe_eng_t;

  // Whole engine state
  typedef struct packed {
    rfe_eng_t        eng;    // Running or finished one-shot
    logic [7:0]      scale;  // Ramp multiplier register
    logic [7:0]      flash;  // Period code and ramp style
    logic [7:0]      tmr1;   // First timer on-time
    logic [7:0]      tmr2;   // Second timer on-time
    logic [7:0]      mode;   // Two bits per channel
    logic [7:0]      ramp;   // Rise and fall codes
    logic [2:0][7:0] cur;    // Channel current codes
    logic [15:0]     tick;   // Clocks within the 1 ms step
    logic [15:0]     phase;  // Milliseconds into the period
    logic [7:0]      pwm;    // Fast PWM counter
    logic [2:0]      drive;  // Sink enables
  } rfe_eng_q_t;

  localparam rfe_eng_q_t ENG_RST = '{
    eng:   ENG_RUN,
    scale: RST_SCALE,
    flash: RST_FLASH,
    tmr1:  RST_TMR,
    tmr2:  RST_TMR,
    mode:  RST_MODE,
    ramp:  RST_RAMP,
    cur:   {3{RST_CUR}},
    tick:  16'h0000,
    phase: 16'h0000,
    pwm:   8'h00,
    drive: 3'b000
  };

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);

  rfe_eng_q_t   s_q;        // Registered state
  rfe_eng_q_t   s_d;        // Next state
  rfe_wr_t      wr;         // Write from the serial port
  rfe_tmr_cfg_t cfg1;       // First timer view
  rfe_tmr_cfg_t cfg2;       // Second timer view
  logic [15:0]  period_ms;  // Current flash period
  logic [15:0]  rise_ms;    // Scaled rise time
  logic [15:0]  fall_ms;    // Scaled fall time
  logic         one_shot;   // Top period code selected
  logic         run;        // Timers may light channels
  logic [7:0]   lvl1;       // First timer level
  logic [7:0]   lvl2;       // Second timer level
  logic [7:0]   lvl;        // Level of channel in loop
  logic [1:0]   chm;        // Mode of channel in loop

  // Ramp code to milliseconds, then shifted by the scale field
  function automatic logic [15:0] ramp_ms(input logic [3:0] code, input logic [1:0] sh);
    logic [15:0] base;
    base = 16'(code * RAMP_STEP_MS);
    return base << sh;
  endfunction

  // Configuration port, writes only
  rfe_i2c_wr #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_out (o_sda_out),
    .o_sda_oe  (o_sda_oe),
    .o_wr      (wr)
  );

  // Derived timing shared by both timers
  always_comb begin
    // Period grows by one step per code
    period_ms = FLASH_BASE_MS + 16'({s_q.flash[FLASH_CODE_LSB +: 7], 7'h00});
    one_shot  = (s_q.flash[FLASH_CODE_LSB +: 7] == FLASH_ONE_SHOT);
    // Rise and fall come from separate nibbles
    rise_ms   = ramp_ms(s_q.ramp[RISE_LSB +: 4], s_q.scale[SCALE_LSB +: 2]);
    fall_ms   = ramp_ms(s_q.ramp[FALL_LSB +: 4], s_q.scale[SCALE_LSB +: 2]);
    run       = (s_q.eng == ENG_RUN);
    cfg1      = '{period_ms: period_ms, on_code: s_q.tmr1, rise_ms: rise_ms,
                  fall_ms: fall_ms, log_style: s_q.flash[RAMP_STYLE_BIT]};
    cfg2      = cfg1;
    cfg2.on_code = s_q.tmr2;
  end

  // First timer; its pulse opens at phase zero
  rfe_ramp_timer u_tmr1 (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_cfg    (cfg1),
    .i_phase  (s_q.phase),
    .i_run    (run),
    .o_level  (lvl1)
  );

  // Second timer, same time slot as the first
  rfe_ramp_timer u_tmr2 (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_cfg    (cfg2),
    .i_phase  (s_q.phase),
    .i_run    (run),
    .o_level  (lvl2)
  );

  // Register writes, time base, period sequencing and channel drive
  always_comb begin
    s_d     = s_q;
    lvl     = 8'h00;
    chm     = 2'b00;
    s_d.pwm = s_q.pwm + 8'h01;

    // Millisecond step divider
    if (s_q.tick == TICK_LAST) begin
      s_d.tick = 16'h0000;
    end else begin
      s_d.tick = s_q.tick + 16'h0001;
    end

    // Period counter advances once per step
    if (s_q.tick == TICK_LAST) begin
      unique case (s_q.eng)
        ENG_RUN: begin
          if (s_q.phase >= period_ms - 16'h0001) begin
            if (one_shot) begin
              // Single flash: hold and stay dark
              s_d.eng = ENG_DONE;
            end else begin
              s_d.phase = 16'h0000;
            end
          end else begin
            s_d.phase = s_q.phase + 16'h0001;
          end
        end
        ENG_DONE: ;
      endcase
    end

    // Accepted byte lands in its register at once
    if (wr.en) begin
      unique case (wr.addr)
        OFS_RAMP_SCALE: s_d.scale = wr.data;
        OFS_FLASH: begin
          // New period restarts the pattern and re-arms a one-shot
          s_d.flash = wr.data;
          s_d.eng   = ENG_RUN;
          s_d.phase = 16'h0000;
          s_d.tick  = 16'h0000;
        end
        OFS_TMR1: s_d.tmr1 = wr.data;
        OFS_TMR2: s_d.tmr2 = wr.data;
        OFS_MODE: s_d.mode = wr.data;
        OFS_RAMP: s_d.ramp = wr.data;
        OFS_CUR0, OFS_CUR1, OFS_CUR2: begin
          // Codes above the top step are held at the top step
          s_d.cur[wr.addr[1:0] - 2'h2] = (wr.data > CUR_MAX) ? CUR_MAX : wr.data;
        end
        default: ;  // Unmapped offsets are ignored
      endcase
    end

    // Per-channel mode mux and PWM compare
    for (int ch = 0; ch < 3; ch++) begin
      chm = s_q.mode[2*ch +: 2];
      unique case (chm)
        MODE_OFF: lvl = 8'h00;
        MODE_ON:  lvl = LEVEL_FULL;
        MODE_T1:  lvl = lvl1;
        MODE_T2:  lvl = lvl2;
      endcase
      // Full level is steady; anything between is pulsed
      s_d.drive[ch] = (lvl == LEVEL_FULL) || (s_q.pwm < lvl);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_q <= ENG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Drive and current straight from flip-flops; done decoded from the engine phase
  assign o_chan_drive   = s_q.drive;
  assign o_chan_current = s_q.cur;
  assign o_pattern_done = (s_q.eng == ENG_DONE);

endmodule // rfe_flash_engine

// *** rfe_flash_engine_checker.sv ***
module rfe_flash_engine_checker
  import rfe_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  // Serial port
  input wire logic                 i_scl,
  input wire logic                 i_sda,
  input wire logic                 o_sda_out,
  input wire logic                 o_sda_oe,
  // Channel outputs
  input wire logic [2:0]           o_chan_drive,
  input wire logic [2:0][7:0]      o_chan_current,
  input wire logic                 o_pattern_done
);
  logic       scl_q;         // Last SCL sample
  logic [7:0] since_fall_q;  // Clocks since SCL fell, saturating

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Reply and update timing is measured from the SCL fall
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      scl_q        <= 1'b1;
      since_fall_q <= 8'hff;
    end else begin
      scl_q        <= i_scl;
      since_fall_q <= (scl_q && !i_scl) ? 8'h00 :
                      ((since_fall_q == 8'hff) ? 8'hff : since_fall_q + 8'h01);
    end
  end

  // Reply pulse must end within 40 clocks
  sequence s_ack_ends;
    ##[1:40] !o_sda_oe;
  endsequence

  a_sda_out_low: assert property (o_sda_out == 1'b0)
    else $error("data output not held low");
  a_current_cap: assert property (o_chan_current[0] <= CUR_MAX &&
      o_chan_current[1] <= CUR_MAX && o_chan_current[2] <= CUR_MAX)
    else $error("current code above limit");
  a_release_quiet: assert property ($rose(i_resetn) |-> o_chan_drive == 3'b000 &&
      o_chan_current == '0 && !o_sda_oe && !o_pattern_done)
    else $error("outputs active at reset release");
  a_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("reply began while clock high");
  a_ack_holds: assert property (o_sda_oe && i_scl |=> o_sda_oe)
    else $error("reply dropped while clock high");
  a_ack_bounded: assert property ($rose(o_sda_oe) |-> s_ack_ends)
    else $error("reply held too long");
  a_ack_timing: assert property ($rose(o_sda_oe) |-> since_fall_q <= 8'h03)
    else $error("reply late after clock fall");
  a_current_on_write: assert property ($changed(o_chan_current) |->
      since_fall_q <= 8'h05)
    else $error("current changed without a write");
  a_done_holds: assert property ($rose(o_pattern_done) |-> o_pattern_done [*8])
    else $error("single flash status not held");
endmodule // rfe_flash_engine_checker

bind rfe_flash_engine rfe_flash_engine_checker u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_chan_drive(o_chan_drive),
  .o_chan_current(o_chan_current), .o_pattern_done(o_pattern_done));

// *** rfe_host_model.sv ***
module rfe_host_model (
  // Clock
  input  wire logic i_clk,
  // Serial lines
  input  wire logic i_sda_wire,
  output logic      o_scl,
  output logic      o_sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idles high
  initial begin
    o_scl     = 1'b1;
    o_sda_drv = 1'b1;
  end

  // Four clocks per level, above the three-clock minimum
  task automatic half();
    repeat (4) @(posedge i_clk);
  endtask

  // Whole byte MSB first, then sample the reply
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_drv <= b[i];
      half();
      o_scl <= 1'b1;
      half();
      o_scl <= 1'b0;
      @(posedge i_clk);
    end
    o_sda_drv <= 1'b1;  // Release so the device can pull low
    half();
    o_scl <= 1'b1;
    half();
    ack = !i_sda_wire;
    o_scl <= 1'b0;
    @(posedge i_clk);
  endtask

  // Start, address, pointer, data, stop
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic ok);
    logic a0, a1, a2;
    @(posedge i_clk);
    o_sda_drv <= 1'b0;
    half();
    o_scl <= 1'b0;
    half();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(val, a2);
    o_sda_drv <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_drv <= 1'b1;
    half();
    ok = a0 & a1 & a2;
  endtask
endmodule // rfe_host_model

// *** rfe_flash_engine_test.sv ***
`define CHECK_EQ(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module rfe_flash_engine_test
  import rfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICKS = 4;      // Shortened pattern step
  localparam int LIMIT = 90000;  // Hang ceiling in clocks

  logic            i_clk;
  logic            i_resetn;
  logic            scl;        // Host clock line
  logic            sda_drv;    // Host data drive, 1 = released
  logic            sda_out;
  logic            sda_oe;
  logic            sda_wire;   // Resolved open-drain level
  logic [2:0]      drive;
  logic [2:0][7:0] cur;
  logic            done;
  logic            ok;
  int              n_mismatch;
  int              n_compared;
  int              cyc;
  int              ca;         // On clocks of the watched channel
  int              cb;
  int              stray;      // Clocks where another channel lit
  int              fl [3];     // Fall-window on clocks: linear, scaled, s-shaped
  logic [7:0]      cur_in [3] = '{8'h10, 8'hc8, 8'hbf};
  logic [7:0]      cur_ex [3] = '{8'h10, 8'hbf, 8'hbf};
  logic [7:0]      mode_in [3] = '{8'h01, 8'h15, 8'h00};
  logic [2:0]      mode_ex [3] = '{3'b001, 3'b111, 3'b000};

  // Pull-up wins unless a party pulls low
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

  rfe_flash_engine #(.TICK_CYCLES_P(TICKS)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_chan_drive(drive),
    .o_chan_current(cur), .o_pattern_done(done));

  rfe_host_model u_host (
    .i_clk(i_clk), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_drv(sda_drv));

  // 25 MHz clock
  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;

  // Cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Register write to our own address, must be acknowledged
  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    u_host.write_reg(I2C_DEV_ADDR, ofs, val, ok);
    `CHECK_EQ(ok, 1'b1)
  endtask

  // Count lit clocks on one channel and stray light elsewhere
  task automatic count_on(input int ch, input int n);
    ca = 0;
    stray = 0;
    repeat (n) begin
      @(negedge i_clk);
      ca += (drive[ch] === 1'b1);
      stray += (drive !== (drive & (3'b001 << ch)));
    end
  endtask

  // Channel 3 on timer two: steady on part, then middle of the fall ramp
  task automatic fall_run(input logic [7:0] s, input logic [7:0] f, output int fall_n);
    wr(OFS_RAMP_SCALE, s);
    wr(OFS_FLASH, f);
    count_on(2, 200);
    `CHECK_EQ(ca, 200)
    `CHECK_EQ(stray, 0)
    repeat (300) @(negedge i_clk);
    count_on(2, 256);
    fall_n = ca;
  endtask

  initial begin
    i_resetn   = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    `CHECK_EQ(drive, 3'b000)
    `CHECK_EQ(cur, 24'h000000)
    `CHECK_EQ(done, 1'b0)
    $display("test reset finished");

    // Static modes, with a foreign address in between
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MODE, mode_in[i]);
      @(negedge i_clk);
      `CHECK_EQ(drive, mode_ex[i])
      if (i == 1) begin
        u_host.write_reg(7'h31, OFS_MODE, 8'h00, ok);
        `CHECK_EQ(ok, 1'b0)
        `CHECK_EQ(drive, 3'b111)
      end
    end
    $display("test modes finished");

    // Channel currents, one clamped
    for (int i = 0; i < 3; i++)
      wr(OFS_CUR0 + 8'(i), cur_in[i]);
    for (int i = 0; i < 3; i++)
      `CHECK_EQ(cur[i], cur_ex[i])
    $display("test currents finished");

    // Half on-time, no ramps, channel 2 on first timer
    wr(OFS_RAMP_SCALE, 8'h00);
    wr(OFS_TMR1, 8'h80);
    wr(OFS_RAMP, 8'h00);
    wr(OFS_MODE, 8'h08);
    wr(OFS_FLASH, 8'h00);
    count_on(1, 256);
    `CHECK_EQ(ca, 256)
    `CHECK_EQ(stray, 0)
    repeat (344) @(negedge i_clk);
    count_on(1, 256);
    `CHECK_EQ(ca, 0)
    repeat (180) @(negedge i_clk);
    count_on(1, 128);
    `CHECK_EQ(ca, 128)
    $display("test timer finished");

    // Rise ramp filling the whole on-time
    wr(OFS_RAMP, 8'h01);
    wr(OFS_FLASH, 8'h00);
    count_on(1, 256);
    cb = ca;
    count_on(1, 256);
    `CHECK_EQ(cb > 0, 1'b1)
    `CHECK_EQ(ca > cb, 1'b1)
    `CHECK_EQ(ca < 256, 1'b1)
    $display("test ramp finished");

    // Second timer, fall only; scaling stretches it, s-shape lifts its upper half
    wr(OFS_TMR2, 8'h40);
    wr(OFS_RAMP, 8'h10);
    wr(OFS_MODE, 8'h30);
    fall_run(8'h00, 8'h00, fl[0]);
    fall_run(8'h01, 8'h00, fl[1]);
    fall_run(8'h01, 8'h80, fl[2]);
    `CHECK_EQ(fl[0] > 0 && fl[0] < 128, 1'b1)
    `CHECK_EQ(fl[1] > fl[0], 1'b1)
    `CHECK_EQ(fl[2] > fl[1], 1'b1)
    wr(OFS_MODE, 8'h08);
    $display("test second timer finished");

    // Single flash then stop
    wr(OFS_RAMP, 8'h00);
    wr(OFS_FLASH, {1'b0, FLASH_ONE_SHOT});
    repeat (30000) @(negedge i_clk);
    `CHECK_EQ(done, 1'b0)
    `CHECK_EQ(drive, 3'b010)
    repeat (36200) @(negedge i_clk);
    `CHECK_EQ(done, 1'b1)
    `CHECK_EQ(drive, 3'b000)
    $display("test one shot finished");
    conclude();
  end
endmodule // rfe_flash_engine_test
